// ### cmc_macrocell_top.sv
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cmc_macrocell_top
  import cmc_pkg::*;
#(
  parameter int unsigned N_IN = CMC_IN_PINS
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic [N_IN-1:0]  in_pin,
  input  wire logic             clk_pin,
  input  wire logic             oe_n_pin,
  input  wire logic [7:0]       io_i,
  output logic [7:0]            io_o,
  output logic [7:0]            io_oe
);

  localparam int unsigned NCOL = N_IN + 2 + CMC_CELLS;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state

  cmc_bus_t    bus_q;
  cmc_bus_t    bus_d;
  logic [11:0] addr_q;
  logic [11:0] addr_d;
  logic        hreadyout_q;
  logic        hreadyout_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic        hresp_q;
  logic [31:0] rdata;

  // Configuration and control
  logic [1:0]  global_q;
  logic [1:0]  global_d;
  logic [7:0]  mode_q;
  logic [7:0]  mode_d;
  logic [7:0]  pol_q;
  logic [7:0]  pol_d;
  logic        preload_q;
  logic        preload_d;
  logic        erase;
  logic        set_secure;
  logic        sig_we_lo;
  logic        sig_we_hi;
  logic        secure;
  logic [63:0] signature;
  logic        wr_now;
  logic        page_true;
  logic        page_comp;
  logic [5:0]  term_idx;

  // Array
  logic [NCOL-1:0] true_q [CMC_ALL_TERMS];
  logic [NCOL-1:0] true_d [CMC_ALL_TERMS];
  logic [NCOL-1:0] comp_q [CMC_ALL_TERMS];
  logic [NCOL-1:0] comp_d [CMC_ALL_TERMS];
  logic [NCOL-1:0] col;
  logic [NCOL-1:0] col_en;
  logic [CMC_ALL_TERMS-1:0] term;

  // Pins and cells
  logic       clk_pin_q;
  logic       clk_rise;
  logic [7:0] fb;
  logic [7:0] cell_val;
  logic [7:0] cell_en;
  logic [7:0] cell_q;
  logic [7:0] io_o_q;
  logic [7:0] io_oe_q;

  assign wr_now    = (bus_q == CMC_BUS_WRITE);
  assign page_true = (addr_q[11:8] == CMC_TRUE_PAGE);
  assign page_comp = (addr_q[11:8] == CMC_COMP_PAGE);
  assign term_idx  = addr_q[7:2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases: writes finish with no wait, reads take one wait state
  // so that a read right behind a write sees the new value.

  always_comb begin
    bus_d       = CMC_BUS_IDLE;
    addr_d      = addr_q;
    hreadyout_d = 1'b1;
    hrdata_d    = hrdata_q;
    unique case (bus_q)
      CMC_BUS_READ: begin
        hrdata_d = rdata;
      end
      CMC_BUS_IDLE, CMC_BUS_WRITE: begin
        if (hsel && hready && htrans[1]) begin
          addr_d = haddr[11:0];
          if (hwrite) begin
            bus_d = CMC_BUS_WRITE;
          end else begin
            bus_d       = CMC_BUS_READ;
            hreadyout_d = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q       <= CMC_BUS_IDLE;
      addr_q      <= 12'h000;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
      hresp_q     <= 1'b0;
    end else begin
      bus_q       <= bus_d;
      addr_q      <= addr_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q    <= hrdata_d;
      hresp_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (addr_q)
      CMC_GLOBAL_OFS: rdata = secure ? 32'h0000_0000 : {30'h0, global_q};
      CMC_MODE_OFS:   rdata = secure ? 32'h0000_0000 : {24'h0, mode_q};
      CMC_POL_OFS:    rdata = secure ? 32'h0000_0000 : {24'h0, pol_q};
      CMC_CTRL_OFS:   rdata = {29'h0, secure, 2'h0};
      CMC_STATUS_OFS: rdata = {16'h0, io_i, cell_q};
      CMC_SIG_LO_OFS: rdata = signature[31:0];
      CMC_SIG_HI_OFS: rdata = signature[63:32];
      default: begin
        if (!secure && page_true) begin
          rdata = 32'(true_q[term_idx]);
        end else if (!secure && page_comp) begin
          rdata = 32'(comp_q[term_idx]);
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; a secured part takes no new pattern until erased

  always_comb begin
    global_d   = global_q;
    mode_d     = mode_q;
    pol_d      = pol_q;
    preload_d  = 1'b0;
    erase      = 1'b0;
    set_secure = 1'b0;
    sig_we_lo  = 1'b0;
    sig_we_hi  = 1'b0;
    true_d     = true_q;
    comp_d     = comp_q;
    if (wr_now && addr_q == CMC_CTRL_OFS) begin
      preload_d  = hwdata[CMC_CTRL_PRELOAD];
      erase      = hwdata[CMC_CTRL_ERASE];
      set_secure = hwdata[CMC_CTRL_SECURE];
    end
    if (wr_now && !secure) begin
      if (addr_q == CMC_GLOBAL_OFS) begin
        global_d = hwdata[1:0];
      end
      if (addr_q == CMC_MODE_OFS) begin
        mode_d = hwdata[7:0];
      end
      if (addr_q == CMC_POL_OFS) begin
        pol_d = hwdata[7:0];
      end
      sig_we_lo = (addr_q == CMC_SIG_LO_OFS);
      sig_we_hi = (addr_q == CMC_SIG_HI_OFS);
      if (page_true) begin
        true_d[term_idx] = hwdata[NCOL-1:0];
      end
      if (page_comp) begin
        comp_d[term_idx] = hwdata[NCOL-1:0];
      end
    end
    // erase wipes array, configuration and security together
    if (erase) begin
      global_d = CMC_GLOBAL_RST;
      mode_d   = CMC_MODE_RST;
      pol_d    = CMC_POL_RST;
      for (int t = 0; t < CMC_ALL_TERMS; t++) begin
        true_d[t] = '0;
        comp_d[t] = '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_q  <= CMC_GLOBAL_RST;
      mode_q    <= CMC_MODE_RST;
      pol_q     <= CMC_POL_RST;
      preload_q <= 1'b0;
      for (int t = 0; t < CMC_ALL_TERMS; t++) begin
        true_q[t] <= '0;
        comp_q[t] <= '0;
      end
    end else begin
      global_q  <= global_d;
      mode_q    <= mode_d;
      pol_q     <= pol_d;
      preload_q <= preload_d;
      true_q    <= true_d;
      comp_q    <= comp_d;
    end
  end

  cmc_secure_store u_store (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .erase      (erase),
    .set_secure (set_secure),
    .sig_we_lo  (sig_we_lo),
    .sig_we_hi  (sig_we_hi),
    .wdata      (hwdata),
    .secure     (secure),
    .signature  (signature)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AND array

  always_comb begin
    col    = {fb, oe_n_pin, clk_pin, in_pin};
    col_en = '1;
    // shared pins reach the array only with registers barred
    if (!global_q[CMC_GLB_ALLOW]) begin
      col_en[N_IN]   = 1'b0;
      col_en[N_IN+1] = 1'b0;
    end
  end

  // unconnected term high, true and complement gives low
  for (genvar t = 0; t < CMC_ALL_TERMS; t++) begin : g_term
    assign term[t] = &((~(true_q[t] & col_en) | col) & (~(comp_q[t] & col_en) | ~col));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared clock pin edge; pins are synchronous to hclk

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_pin_q <= 1'b0;
    end else begin
      clk_pin_q <= clk_pin;
    end
  end

  // rising edge of the shared clock pin
  assign clk_rise = clk_pin && !clk_pin_q;

  for (genvar c = 0; c < CMC_CELLS; c++) begin : g_cell
    cmc_cell u_cell (
      .hclk                 (hclk),
      .hresetn              (hresetn),
      .register_allow_bit   (global_q[CMC_GLB_ALLOW]),
      .emulation_select_bit (global_q[CMC_GLB_EMUL]),
      .cell_mode_bit        (mode_q[c]),
      .cell_polarity_bit    (pol_q[c]),
      .edge_cell            (c == CMC_FIRST_CELL || c == CMC_LAST_CELL),
      .centre_cell          (c == CMC_CENTRE_A || c == CMC_CENTRE_B),
      .pterm                (term[c*CMC_TERMS +: CMC_TERMS]),
      .clk_rise             (clk_rise),
      .oe_n_pin             (oe_n_pin),
      .own_pin              (io_i[c]),
      .adj_pin              (io_i[c ^ 1]),
      .preload              (preload_q),
      .preload_val          (io_i[c]),
      .pin_val              (cell_val[c]),
      .pin_en               (cell_en[c]),
      .feedback             (fb[c]),
      .q_state              (cell_q[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers registered; costs one hclk of latency on every path

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_o_q  <= 8'h00;
      io_oe_q <= 8'h00;
    end else begin
      // cleared flip-flops show high on registered pins
      io_o_q  <= cell_val;
      io_oe_q <= cell_en;
    end
  end

  assign io_o      = io_o_q;
  assign io_oe     = io_oe_q;
  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = hresp_q;

endmodule
`default_nettype wire

// ### cmc_pkg.sv
package cmc_pkg;

  // Geometry
  localparam int unsigned CMC_CELLS      = 8;
  localparam int unsigned CMC_TERMS      = 8;
  localparam int unsigned CMC_ALL_TERMS  = CMC_CELLS * CMC_TERMS;
  localparam int unsigned CMC_IN_PINS    = 12;
  localparam int unsigned CMC_SIG_BITS   = 64;
  localparam int unsigned CMC_FIRST_CELL = 0;
  localparam int unsigned CMC_LAST_CELL  = 7;
  localparam int unsigned CMC_CENTRE_A   = 3;
  localparam int unsigned CMC_CENTRE_B   = 4;

  // Register byte offsets
  localparam logic [11:0] CMC_GLOBAL_OFS   = 12'h000;
  localparam logic [11:0] CMC_MODE_OFS     = 12'h004;
  localparam logic [11:0] CMC_POL_OFS      = 12'h008;
  localparam logic [11:0] CMC_CTRL_OFS     = 12'h00C;
  localparam logic [11:0] CMC_STATUS_OFS   = 12'h010;
  localparam logic [11:0] CMC_SIG_LO_OFS   = 12'h014;
  localparam logic [11:0] CMC_SIG_HI_OFS   = 12'h018;
  localparam logic [3:0]  CMC_TRUE_PAGE    = 4'h1;
  localparam logic [3:0]  CMC_COMP_PAGE    = 4'h2;

  // Field positions
  localparam int unsigned CMC_GLB_ALLOW    = 0;
  localparam int unsigned CMC_GLB_EMUL     = 1;
  localparam int unsigned CMC_CTRL_PRELOAD = 0;
  localparam int unsigned CMC_CTRL_ERASE   = 1;
  localparam int unsigned CMC_CTRL_SECURE  = 2;

  // Reset values
  localparam logic [1:0]  CMC_GLOBAL_RST   = 2'h0;
  localparam logic [7:0]  CMC_MODE_RST     = 8'h00;
  localparam logic [7:0]  CMC_POL_RST      = 8'h00;

  typedef enum logic [1:0] {
    CMC_BUS_IDLE,
    CMC_BUS_WRITE,
    CMC_BUS_READ
  } cmc_bus_t;

endpackage

// ### cmc_cell.sv
`timescale 1ns/1ps
`default_nettype none
module cmc_cell
  import cmc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       register_allow_bit,
  input  wire logic       emulation_select_bit,
  input  wire logic       cell_mode_bit,
  input  wire logic       cell_polarity_bit,
  input  wire logic       edge_cell,
  input  wire logic       centre_cell,
  input  wire logic [7:0] pterm,
  input  wire logic       clk_rise,
  input  wire logic       oe_n_pin,
  input  wire logic       own_pin,
  input  wire logic       adj_pin,
  input  wire logic       preload,
  input  wire logic       preload_val,
  output logic            pin_val,
  output logic            pin_en,
  output logic            feedback,
  output logic            q_state
);

  logic q_q;
  logic q_d;
  logic sum;
  logic d_in;
  logic comb_val;
  logic fb_ctl;
  logic legal;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    legal = (!register_allow_bit && emulation_select_bit) ||
            (register_allow_bit && !(!emulation_select_bit && cell_mode_bit && 1'b0));
    legal = legal && !(register_allow_bit && emulation_select_bit && !cell_mode_bit);
    sum = |pterm[6:0];
    if (!(emulation_select_bit && cell_mode_bit)) begin
      sum = sum | pterm[7];
    end
    d_in     = sum ^ cell_polarity_bit;
    comb_val = ~d_in;
    q_d      = q_q;
    if (preload) begin
      q_d = preload_val;
    end else if (clk_rise && !register_allow_bit && emulation_select_bit && !cell_mode_bit) begin
      q_d = d_in;
    end
    // output select, registered path drives inverted Q
    if (emulation_select_bit && !cell_mode_bit) begin
      pin_val = ~q_q;
    end else begin
      pin_val = comb_val;
    end
    unique case ({emulation_select_bit, cell_mode_bit})
      2'b10:   pin_en = !oe_n_pin;
      2'b11:   pin_en = pterm[7];
      2'b00:   pin_en = 1'b1;
      default: pin_en = 1'b0;
    endcase
    pin_en = pin_en && legal;
    // edge cells steer feedback by inverse allow bit
    fb_ctl = edge_cell ? !register_allow_bit : emulation_select_bit;
    unique case ({fb_ctl, cell_mode_bit})
      2'b10:   feedback = ~q_q;
      2'b11:   feedback = own_pin;
      // combinatorial output feeds back; centre cells do not
      2'b00:   feedback = centre_cell ? 1'b0 : comb_val;
      default: feedback = adj_pin;
    endcase
    q_state = q_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_q <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

endmodule
`default_nettype wire

// ### cmc_secure_store.sv
`timescale 1ns/1ps
`default_nettype none
module cmc_secure_store
  import cmc_pkg::*;
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    erase,
  input  wire logic                    set_secure,
  input  wire logic                    sig_we_lo,
  input  wire logic                    sig_we_hi,
  input  wire logic [31:0]             wdata,
  output logic                         secure,
  output logic [CMC_SIG_BITS-1:0]      signature
);

  logic                    sec_q;
  logic                    sec_d;
  logic [CMC_SIG_BITS-1:0] sig_q;
  logic [CMC_SIG_BITS-1:0] sig_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sec_d = sec_q;
    sig_d = sig_q;
    // only an erase clears the bit
    if (erase) begin
      sec_d = 1'b0;
      sig_d = '0;
    end else begin
      if (set_secure) begin
        sec_d = 1'b1;
      end
      if (sig_we_lo) begin
        sig_d[31:0] = wdata;
      end
      if (sig_we_hi) begin
        sig_d[63:32] = wdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_q <= 1'b0;
      sig_q <= '0;
    end else begin
      sec_q <= sec_d;
      sig_q <= sig_d;
    end
  end

  assign secure    = sec_q;
  assign signature = sig_q;

endmodule
`default_nettype wire

// ### cmc_macrocell_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cmc_checker
  import cmc_pkg::*;
#(
  parameter int unsigned N_IN = CMC_IN_PINS
)
(
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire logic [31:0]     hrdata,
  input wire logic [N_IN-1:0] in_pin,
  input wire logic            clk_pin,
  input wire logic            oe_n_pin,
  input wire logic [7:0]      io_o,
  input wire logic [7:0]      io_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic        ph_q;
  logic        wr_q;
  logic        sec_q;
  logic [11:0] ad_q;
  logic [1:0]  glb_q;
  logic [7:0]  mode_q;
  logic [7:0]  unsup;
  logic [63:0] sig_q;
  logic [2:0]  quiet_q;
  logic        rd_end;

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the configuration, rebuilt from bus writes only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q    <= 1'b0;
      wr_q    <= 1'b0;
      ad_q    <= 12'h000;
      glb_q   <= 2'h0;
      mode_q  <= 8'h00;
      sig_q   <= 64'h0;
      sec_q   <= 1'b0;
      quiet_q <= 3'h0;
    end else if (hready) begin
      ph_q    <= hsel & htrans[1];
      wr_q    <= hwrite;
      ad_q    <= haddr[11:0];
      // Quiet count pauses in wait states: conservative, never early
      quiet_q <= (ph_q && wr_q) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
      if (ph_q && wr_q) begin
        case (ad_q)
          CMC_GLOBAL_OFS: if (!sec_q) glb_q <= hwdata[1:0];
          CMC_MODE_OFS:   if (!sec_q) mode_q <= hwdata[7:0];
          CMC_SIG_LO_OFS: if (!sec_q) sig_q[31:0] <= hwdata;
          CMC_SIG_HI_OFS: if (!sec_q) sig_q[63:32] <= hwdata;
          CMC_CTRL_OFS: begin
            if (hwdata[CMC_CTRL_ERASE]) begin
              glb_q  <= 2'h0;
              mode_q <= 8'h00;
              sig_q  <= 64'h0;
              sec_q  <= 1'b0;
            end else if (hwdata[CMC_CTRL_SECURE]) begin
              sec_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    unsup = 8'h00;
    if (glb_q == 2'h0) unsup = 8'hFF;
    if (glb_q == 2'h3) unsup = ~mode_q;
  end
  assign rd_end = ph_q && !wr_q && hready;

  ////////////////////////////////////////////////////////////////////////////////
  a_reg_enable: assert property (
    $past(glb_q) == 2'h2 |-> ((io_oe ^ {8{!$past(oe_n_pin)}}) & ~$past(mode_q)) == 8'h00)
    else $error("registered cell enable not from shared pin");
  a_input_off: assert property (
    $past(glb_q) == 2'h1 |-> (io_oe & $past(mode_q)) == 8'h00)
    else $error("dedicated input cell drives its pin");
  a_comb_on: assert property (
    $past(glb_q) == 2'h1 |-> (io_oe | $past(mode_q)) == 8'hFF)
    else $error("combinatorial output cell not driving");
  a_unsup_off: assert property (
    (io_oe & $past(unsup)) == 8'h00)
    else $error("unsupported cell drives its pin");
  a_clk_rise: assert property (
    $past(glb_q) == 2'h2 && quiet_q > 3'h3 && ((io_o ^ $past(io_o)) & ~mode_q) != 8'h00
    |-> $past(clk_pin, 2) && !$past(clk_pin, 3))
    else $error("registered pin changed without a clock rise");
  a_sec_hide: assert property (
    rd_end && sec_q && (ad_q == CMC_GLOBAL_OFS || ad_q == CMC_MODE_OFS || ad_q == CMC_POL_OFS)
    |-> hrdata == 32'h0)
    else $error("configuration readable while secured");
  a_sig_read: assert property (
    rd_end && (ad_q == CMC_SIG_LO_OFS || ad_q == CMC_SIG_HI_OFS)
    |-> hrdata == ((ad_q == CMC_SIG_LO_OFS) ? sig_q[31:0] : sig_q[63:32]))
    else $error("signature read differs from written value");
  a_sec_sticky: assert property (
    rd_end && ad_q == CMC_CTRL_OFS |-> hrdata[CMC_CTRL_SECURE] == sec_q)
    else $error("security bit state wrong");
endmodule
`default_nettype wire

// ### cmc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmc_board_model (
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  input  wire logic       hclk,
  input  wire logic [7:0] io_o,
  input  wire logic [7:0] io_oe,
  output logic      [7:0] io_i
);
  logic [7:0] float_q = 8'h5A;

  // Undriven pins wander so a stale level never passes for data
  always_ff @(posedge hclk) begin
    float_q <= ~float_q;
  end

  // board levels reach the pins when the cell lets go
  always_comb begin
    io_i = (io_oe & io_o) | (~io_oe & drv_en & drv_val) | (~io_oe & ~drv_en & float_q);
  end
endmodule
`default_nettype wire

// ### tb_configurable_output_macrocell.sv
`timescale 1ns/1ps
`default_nettype none
module tb_configurable_output_macrocell
  import cmc_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, clk_pin, oe_n_pin, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] seed_q = 32'h340D;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] in_pin;
  logic [7:0]  io_i, io_o, io_oe, drv_en, drv_val;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  cmc_macrocell_top #(.N_IN(12)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_pin(in_pin),
    .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_i(io_i), .io_o(io_o), .io_oe(io_oe));
  cmc_board_model i_board (.drv_en(drv_en), .drv_val(drv_val), .hclk(hclk), .io_o(io_o),
    .io_oe(io_oe), .io_i(io_i));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q;
  endfunction

  // Pin level from sum and polarity; also a registered pin after its clock
  function automatic logic [7:0] comb_pin(logic [7:0] sum, logic [7:0] pol);
    return ~(sum ^ pol);
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hwrite <= w;
    haddr  <= {20'h00000, a};
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic term(logic [3:0] pg, int t, logic [31:0] m);
    wr({pg, 6'(t), 2'b00}, m);
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Pin-side results are eight bits wide; widened on purpose here
  task automatic chk_pin(string name, logic [7:0] exp, logic [7:0] got);
    chk(name, {24'h000000, exp}, {24'h000000, got});
  endtask

  task automatic rc(string name, logic [11:0] a, logic [31:0] m, logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(name, e, q & m);
  endtask

  task automatic clk_rise();
    clk_pin <= 1'b0;
    tick(2);
    clk_pin <= 1'b1;
    tick(3);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Runs take a few hundred cycles; this bound only catches a hang
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    logic [7:0]  p;
    logic [7:0]  v;
    logic [63:0] s;
    int          c;
    hresetn  = 1'b0;
    hsel     = 1'b1;
    haddr    = 32'h0;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    clk_pin  = 1'b0;
    oe_n_pin = 1'b0;
    drv_en   = 8'h00;
    drv_val  = 8'h00;
    in_pin   = 12'(rnd());
    tick(10);
    hresetn <= 1'b1;
    rc("global", CMC_GLOBAL_OFS, 32'hFFFFFFFF, 32'h0);
    rc("mode", CMC_MODE_OFS, 32'hFFFFFFFF, 32'h0);
    rc("unmapped", 12'h01C, 32'hFFFFFFFF, 32'h0);
    chk_pin("io_oe", 8'h00, io_oe);
    $display("test reset_state done");
    p = 8'(rnd());
    wr(CMC_GLOBAL_OFS, 32'h2);
    wr(CMC_MODE_OFS, 32'h0);
    wr(CMC_POL_OFS, {24'h0, p});
    tick(2);
    chk_pin("power_up_pin", 8'hFF, io_o);
    chk_pin("enable_on", 8'hFF, io_oe);
    oe_n_pin <= 1'b1;
    tick(2);
    chk_pin("enable_off", 8'h00, io_oe);
    oe_n_pin <= 1'b0;
    clk_rise();
    chk_pin("pin_after_rise", comb_pin(8'hFF, p), io_o);
    rc("state", CMC_STATUS_OFS, 32'hFF, {24'h0, ~p});
    wr(CMC_POL_OFS, {24'h0, ~p});
    tick(3);
    chk_pin("no_capture_high", comb_pin(8'hFF, p), io_o);
    clk_rise();
    chk_pin("capture_rise", comb_pin(8'hFF, ~p), io_o);
    $display("test registered done");
    oe_n_pin <= 1'b1;
    tick(2);
    v = 8'(rnd());
    drv_val <= v;
    drv_en  <= 8'hFF;
    wr(CMC_CTRL_OFS, 32'h1);
    tick(2);
    drv_en <= 8'h00;
    rc("preload_state", CMC_STATUS_OFS, 32'hFF, {24'h0, v});
    oe_n_pin <= 1'b0;
    tick(2);
    chk_pin("preload_pin", ~v, io_o);
    $display("test preload done");
    p = 8'(rnd());
    c = int'(rnd() & 32'h7);
    wr(CMC_GLOBAL_OFS, 32'h3);
    wr(CMC_MODE_OFS, 32'hFF);
    wr(CMC_POL_OFS, {24'h0, p});
    tick(2);
    chk_pin("io_enable", 8'hFF, io_oe);
    chk_pin("empty_term", comb_pin(8'hFF, p), io_o);
    term(CMC_TRUE_PAGE, c * 8 + 7, 32'h1);
    term(CMC_COMP_PAGE, c * 8 + 7, 32'h1);
    tick(2);
    chk_pin("contradict_term", 8'(~(8'h01 << c)), io_oe);
    wr(CMC_GLOBAL_OFS, 32'h2);
    tick(2);
    chk_pin("registered_io", 8'(~(8'h01 << c)), io_oe);
    $display("test combinatorial_io done");
    for (int t = 17; t < 24; t++) begin
      term(CMC_TRUE_PAGE, t, 32'h1);
      term(CMC_COMP_PAGE, t, 32'h1);
    end
    term(CMC_TRUE_PAGE, 16, 32'h4000);
    term(CMC_COMP_PAGE, 16, 32'h0);
    wr(CMC_GLOBAL_OFS, 32'h1);
    wr(CMC_MODE_OFS, 32'h3);
    wr(CMC_POL_OFS, 32'h4);
    for (int b = 0; b < 2; b++) begin
      drv_en  <= 8'h03;
      drv_val <= {6'h00, b[0], 1'b0};
      tick(3);
      chk_pin("adjacent_input", 8'(b), {7'h00, io_o[2]});
      chk_pin("enable_split", 8'hFC, io_oe);
    end
    drv_en <= 8'h00;
    // Cell 3 would feed back high here; a centre cell must feed back nothing
    wr(CMC_POL_OFS, 32'hC);
    term(CMC_TRUE_PAGE, 16, 32'h20000);
    tick(3);
    chk_pin("centre_no_feedback", 8'h00, {7'h00, io_o[2]});
    $display("test dedicated_input done");
    wr(CMC_CTRL_OFS, 32'h2);
    s = {rnd(), rnd()};
    wr(CMC_SIG_LO_OFS, s[31:0]);
    wr(CMC_SIG_HI_OFS, s[63:32]);
    wr(CMC_GLOBAL_OFS, 32'h2);
    wr(CMC_CTRL_OFS, 32'h4);
    rc("secure", CMC_CTRL_OFS, 32'h4, 32'h4);
    rc("hidden", CMC_GLOBAL_OFS, 32'hFFFFFFFF, 32'h0);
    wr(CMC_CTRL_OFS, 32'h0);
    rc("secure_kept", CMC_CTRL_OFS, 32'h4, 32'h4);
    wr(CMC_SIG_LO_OFS, ~s[31:0]);
    rc("sig_lo", CMC_SIG_LO_OFS, 32'hFFFFFFFF, s[31:0]);
    rc("sig_hi", CMC_SIG_HI_OFS, 32'hFFFFFFFF, s[63:32]);
    wr(CMC_CTRL_OFS, 32'h6);
    rc("erased_secure", CMC_CTRL_OFS, 32'h4, 32'h0);
    rc("erased_sig", CMC_SIG_HI_OFS, 32'hFFFFFFFF, 32'h0);
    $display("test security done");
    tally_and_finish();
  end
endmodule

bind cmc_macrocell_top cmc_checker #(.N_IN(N_IN)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .in_pin(in_pin),
  .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_o(io_o), .io_oe(io_oe));
`default_nettype wire
